// >>> hw/adcaq_regs.vh
// Register map, field positions, reset values and timing counts of the
// acquisition register block. Definitions only; included by the design files.
// Operation
// - Writing one to command bit 0 starts one conversion on the addressed channel.
// - Writing one to command bit 1 starts a pipelined run through all channels.
// - Command bits 4..2 pick the channel for single-channel conversion.
// - Command bit 5 enables the sequencer; bit 6 is reserved.
// - Command bit 7 enables the interrupt on single conversion done.
// - Command bit 8 lets the burst sequencer start acquisition runs.
// - Command bits 11..9 name the channel that raises the sequencer interrupt.
// - Command bits 13..12 select the input source feeding channel 7.
// - Command bit 14 selects the external zero-volt reference.
// - Command bit 15 selects the external full-scale reference.
// - Status is read-only except bits 12..8, input buffer enables channels 4..0, and reserved bit 15.
// - Results hold ten-bit two's complement in bits 11..2, sign copied to 15..12.
// - After a conversion is stored, result bits 1..0 read as zero.
`ifndef ADCAQ_REGS_VH
`define ADCAQ_REGS_VH

// Register indices; byte address is four times the index
`define ADCAQ_IDX_CMD 16'he000
`define ADCAQ_IDX_STA 16'he001
`define ADCAQ_IDX_CH6 16'he002
`define ADCAQ_IDX_CH7 16'he003
`define ADCAQ_IDX_CH0 16'he004
`define ADCAQ_IDX_IRQ_STA 16'he00a
`define ADCAQ_IDX_IRQ_MSK 16'he00b

// Command fields
`define ADCAQ_CMD_SINGLE 0
`define ADCAQ_CMD_PIPE 1
`define ADCAQ_CMD_ADDR_LO 2
`define ADCAQ_CMD_SEQ_EN 5
`define ADCAQ_CMD_RSVD 6
`define ADCAQ_CMD_SIRQ_EN 7
`define ADCAQ_CMD_BURST_EN 8
`define ADCAQ_CMD_ICH_LO 9
`define ADCAQ_CMD_SRC7_LO 12
`define ADCAQ_CMD_ZREF 14
`define ADCAQ_CMD_FREF 15
// Writable command bits: all but starts and reserved bit 6
`define ADCAQ_CMD_WMASK 16'hffbc
`define ADCAQ_CMD_RESET 16'h0000

// Status fields
`define ADCAQ_STA_BUF_LO 8
`define ADCAQ_STA_CARRY 13
`define ADCAQ_STA_BORROW 14
`define ADCAQ_STA_RSVD 15
`define ADCAQ_STA_WMASK 16'h9f00

// Interrupt status bits
`define ADCAQ_IRQ_SINGLE 0
`define ADCAQ_IRQ_SEQ 1

// Conversion time per channel, ns, and cycles at 20 MHz
`define ADCAQ_CLK_NS 50
`define ADCAQ_CONV_NS 1100
`define ADCAQ_CONV_CYC ((`ADCAQ_CONV_NS + `ADCAQ_CLK_NS - 1) / `ADCAQ_CLK_NS)

`endif

// >>> hw/adcaq_result_fmt.v
// Formats a raw ten-bit converter word into the stored result layout.
// Assumes the raw word is two's complement, bit 9 the sign.
`timescale 1ns/1ps
module adcaq_result_fmt (
  // Raw sample
  input wire [9:0] raw_i,
  // Formatted result word
  output wire [15:0] word_o
);
  // Sign copied up, value in 11..2, low bits zero
  assign word_o = {{4{raw_i[9]}}, raw_i, 2'b00};
endmodule

// >>> hw/adcaq_conv_timer.v
// Counts one conversion time for the converter in front of the block.
// Assumes start is a single-cycle pulse accepted only while idle.
`timescale 1ns/1ps
`include "adcaq_regs.vh"
module adcaq_conv_timer #(
  parameter CYCLES = `ADCAQ_CONV_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  output wire busy_o,
  output wire done_o
);
  reg [15:0] cnt_reg;
  reg done_reg;

  // Down-counter; done pulses as the count ends
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (cnt_reg == 16'h0001);
      if (start_i && cnt_reg == 16'h0000) begin
        cnt_reg <= CYCLES[15:0];
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  assign busy_o = (cnt_reg != 16'h0000);
  assign done_o = done_reg;
endmodule

// >>> hw/adcaq_top.v
// Acquisition register block: Wishbone slave, sequencer and result store.
// Assumes a classic Wishbone master, and a converter whose sample is valid
// on adc_data_i when the conversion time has elapsed.
`timescale 1ns/1ps
`include "adcaq_regs.vh"
module adcaq_top #(
  parameter CONV_CYCLES = `ADCAQ_CONV_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [17:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Converter side
  input wire [9:0] adc_data_i,
  input wire adc_borrow_i,
  input wire adc_carry_i,
  output reg [2:0] adc_chan_o,
  output reg adc_start_o,
  output reg [1:0] ch7_source_o,
  output reg ext_zero_ref_o,
  output reg ext_full_ref_o,
  output reg [4:0] input_buffer_o,
  // Burst sequencer trigger
  input wire burst_start_i,
  // Interrupt
  output wire irq_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_NEXT = 2'd2;

  reg [15:0] cmd_reg;
  reg [15:0] sta_reg;
  reg [15:0] res_reg [0:7];
  reg [1:0] irq_sta_reg;
  reg [1:0] irq_msk_reg;
  reg [1:0] state_reg;
  reg pipe_reg;
  reg [7:0] busy_reg;
  wire [15:0] idx;
  wire [15:0] wdat;
  wire [15:0] fmt_word;
  wire tmr_done;
  wire req;
  wire wr;
  wire rd;
  wire hit_res;
  wire [2:0] res_sel;
  wire wr_cmd;
  wire single_go;
  wire pipe_go;
  reg [15:0] rd_mux;

  // Word index from the byte address; low half of the data bus carries 16 bits
  assign idx = adr_i[17:2];
  assign wdat = dat_i[15:0];
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && (sel_i[1:0] == 2'b11);
  assign rd = req && !we_i;
  assign wr_cmd = wr && (idx == `ADCAQ_IDX_CMD);
  // Result registers: ch6,ch7 at e002/e003, ch0..ch5 at e004..e009
  assign hit_res = (idx >= `ADCAQ_IDX_CH6) && (idx <= 16'he009);
  assign res_sel = (idx == `ADCAQ_IDX_CH6) ? 3'd6 :
                   (idx == `ADCAQ_IDX_CH7) ? 3'd7 :
                   idx[2:0] - 3'd4;

  // Start strobes, accepted only with the sequencer enabled and idle
  assign single_go = wr_cmd && wdat[`ADCAQ_CMD_SINGLE]
                     && cmd_reg[`ADCAQ_CMD_SEQ_EN];
  assign pipe_go = (wr_cmd && wdat[`ADCAQ_CMD_PIPE]
                    || burst_start_i && cmd_reg[`ADCAQ_CMD_BURST_EN])
                   && cmd_reg[`ADCAQ_CMD_SEQ_EN];

  adcaq_conv_timer #(
    .CYCLES(CONV_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(adc_start_o),
    .busy_o(),
    .done_o(tmr_done)
  );

  adcaq_result_fmt u_fmt (
    .raw_i(adc_data_i),
    .word_o(fmt_word)
  );

  // Bus acknowledge: one cycle after the request, dropped the next cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Read data mux
  always @* begin
    rd_mux = 16'h0000;
    if (idx == `ADCAQ_IDX_CMD) begin
      rd_mux = cmd_reg & `ADCAQ_CMD_WMASK;
    end else if (idx == `ADCAQ_IDX_STA) begin
      rd_mux = {sta_reg[15:8], busy_reg};
    end else if (hit_res) begin
      rd_mux = res_reg[res_sel];
    end else if (idx == `ADCAQ_IDX_IRQ_STA) begin
      rd_mux = {14'h0000, irq_sta_reg};
    end else if (idx == `ADCAQ_IDX_IRQ_MSK) begin
      rd_mux = {14'h0000, irq_msk_reg};
    end
  end

  // Read data register; unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd) begin
      dat_o <= {16'h0000, rd_mux};
    end
  end

  // Command register; start bits self-clear and reserved bit stays zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= `ADCAQ_CMD_RESET;
    end else if (wr_cmd) begin
      cmd_reg <= wdat & `ADCAQ_CMD_WMASK;
    end
  end

  // Analog controls driven from command and status fields
  always @(posedge clk_i) begin
    if (rst_i) begin
      ch7_source_o <= 2'b00;
      ext_zero_ref_o <= 1'b0;
      ext_full_ref_o <= 1'b0;
      input_buffer_o <= 5'h00;
    end else begin
      ch7_source_o <= cmd_reg[`ADCAQ_CMD_SRC7_LO +: 2];
      ext_zero_ref_o <= cmd_reg[`ADCAQ_CMD_ZREF];
      ext_full_ref_o <= cmd_reg[`ADCAQ_CMD_FREF];
      input_buffer_o <= sta_reg[`ADCAQ_STA_BUF_LO +: 5];
    end
  end

  // Status: writable buffer enables and reserved bit, borrow and carry latched at conversion end
  always @(posedge clk_i) begin
    if (rst_i) begin
      sta_reg <= 16'h0000;
    end else begin
      if (wr && idx == `ADCAQ_IDX_STA) begin
        sta_reg[15] <= wdat[15];
        sta_reg[12:8] <= wdat[12:8];
      end
      if (tmr_done) begin
        sta_reg[`ADCAQ_STA_BORROW] <= adc_borrow_i;
        sta_reg[`ADCAQ_STA_CARRY] <= adc_carry_i;
      end
      sta_reg[7:0] <= 8'h00;
    end
  end

  // Sequencer: single conversion or pipelined run over channels 0..7
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      pipe_reg <= 1'b0;
      adc_chan_o <= 3'd0;
      adc_start_o <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (pipe_go) begin
            pipe_reg <= 1'b1;
            adc_chan_o <= 3'd0;
            adc_start_o <= 1'b1;
            state_reg <= ST_CONV;
          end else if (single_go) begin
            pipe_reg <= 1'b0;
            adc_chan_o <= wdat[`ADCAQ_CMD_ADDR_LO +: 3];
            adc_start_o <= 1'b1;
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (tmr_done) begin
            state_reg <= (pipe_reg && adc_chan_o != 3'd7) ? ST_NEXT : ST_IDLE;
          end
        end
        ST_NEXT: begin
          adc_chan_o <= adc_chan_o + 3'd1;
          adc_start_o <= 1'b1;
          state_reg <= ST_CONV;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-channel busy flags and result store, one entry per channel
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_chan
      always @(posedge clk_i) begin
        if (rst_i) begin
          busy_reg[g] <= 1'b0;
          res_reg[g] <= 16'h0000;
        end else begin
          if (adc_start_o && adc_chan_o == g) begin
            busy_reg[g] <= 1'b1;
          end else if (tmr_done && adc_chan_o == g) begin
            busy_reg[g] <= 1'b0;
          end
          if (tmr_done && adc_chan_o == g) begin
            res_reg[g] <= fmt_word;
          end else if (wr && hit_res && res_sel == g) begin
            res_reg[g] <= wdat;
          end
        end
      end
    end
  endgenerate

  // Sticky interrupt status; set wins over the clear-on-read
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_sta_reg <= 2'b00;
      irq_msk_reg <= 2'b00;
    end else begin
      if (wr && idx == `ADCAQ_IDX_IRQ_MSK) begin
        irq_msk_reg <= wdat[1:0];
      end
      irq_sta_reg[`ADCAQ_IRQ_SINGLE] <=
        (tmr_done && !pipe_reg && cmd_reg[`ADCAQ_CMD_SIRQ_EN])
        || (irq_sta_reg[`ADCAQ_IRQ_SINGLE] && !(rd && idx == `ADCAQ_IDX_IRQ_STA));
      irq_sta_reg[`ADCAQ_IRQ_SEQ] <=
        (tmr_done && pipe_reg
         && adc_chan_o == cmd_reg[`ADCAQ_CMD_ICH_LO +: 3])
        || (irq_sta_reg[`ADCAQ_IRQ_SEQ] && !(rd && idx == `ADCAQ_IDX_IRQ_STA));
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq_o = |(irq_sta_reg & irq_msk_reg);
endmodule

// >>> sim/adcaq_asserts.sv
// Concurrent checks on the ports of the acquisition register block.
// Assumes a short conversion time of a few cycles set by the bench.
`timescale 1ns/1ps
module adcaq_asserts #(
  parameter CONV_CYCLES = 3
) (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Wishbone
  input logic cyc_i,
  input logic stb_i,
  input logic we_i,
  input logic [17:0] adr_i,
  input logic [3:0] sel_i,
  input logic [31:0] dat_i,
  input logic [31:0] dat_o,
  input logic ack_o,
  // Converter side and interrupt
  input logic [2:0] adc_chan_o,
  input logic adc_start_o,
  input logic [1:0] ch7_source_o,
  input logic ext_zero_ref_o,
  input logic ext_full_ref_o,
  input logic [4:0] input_buffer_o,
  input logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A write of the low half that the slave has answered
  logic wr_ok;
  assign wr_ok = ack_o && we_i && sel_i[1:0] == 2'b11;
  // Answered writes to the command and the status register
  logic wr_cmd_ok, wr_sta_ok;
  assign wr_cmd_ok = wr_ok && adr_i[17:2] == 16'he000;
  assign wr_sta_ok = wr_ok && adr_i[17:2] == 16'he001;
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held over one cycle");
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  AST_DAT_HI: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_ZREF: assert property (wr_cmd_ok |=> ext_zero_ref_o == $past(dat_i[14]))
    else $error("zero reference select wrong");
  AST_FREF: assert property (wr_cmd_ok |=> ext_full_ref_o == $past(dat_i[15]))
    else $error("full-scale reference select wrong");
  AST_SRC7: assert property (wr_cmd_ok |=> ch7_source_o == $past(dat_i[13:12]))
    else $error("channel 7 source wrong");
  AST_BUF: assert property (wr_sta_ok |=> input_buffer_o == $past(dat_i[12:8]))
    else $error("buffer enables wrong");
  AST_START_GAP: assert property (adc_start_o |=> !adc_start_o [*3])
    else $error("start pulses too close");
  AST_CHAN_HOLD: assert property (adc_start_o |=> $stable(adc_chan_o) [*2])
    else $error("channel changed during conversion");
  // Main scenarios
  cover property (adc_start_o);
  cover property (irq_o);
  cover property (wr_ok && adr_i[17:2] == 16'he001);
endmodule
bind adcaq_top adcaq_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_adcaq_asserts (.clk_i, .rst_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .adc_chan_o, .adc_start_o,
  .ch7_source_o, .ext_zero_ref_o, .ext_full_ref_o, .input_buffer_o, .irq_o);

// >>> sim/tb_top.sv
// Self-checking bench for the acquisition register block.
// Assumes the block answers every Wishbone cycle with a one-cycle ack.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, burst_start_i = 1'b0;
  logic adc_borrow_i = 1'b0, adc_carry_i = 1'b0;
  logic [17:0] adr_i = 18'h00000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [9:0] adc_data_i = 10'h000;
  logic [31:0] dat_o;
  logic ack_o, adc_start_o, ext_zero_ref_o, ext_full_ref_o, irq_o;
  logic [2:0] adc_chan_o, last_chan;
  logic [1:0] ch7_source_o;
  logic [4:0] input_buffer_o;
  logic [15:0] q;
  int errors = 0, comparisons = 0, cycles = 0, starts = 0;
  // Block with a short conversion time
  adcaq_top #(.CONV_CYCLES(3)) i_adcaq_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .adc_data_i, .adc_borrow_i, .adc_carry_i, .adc_chan_o,
    .adc_start_o, .ch7_source_o, .ext_zero_ref_o, .ext_full_ref_o, .input_buffer_o,
    .burst_start_i, .irq_o);
  always #25 clk_i = ~clk_i;
  // Cycle ceiling and start pulse count
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (adc_start_o === 1'b1) begin
      starts <= starts + 1;
      last_chan <= adc_chan_o;
    end
    if (cycles == 5000) begin
      errors++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic Wishbone cycle; read data lands in q
  task automatic wb(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    sel_i <= 4'hf;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    // A missing answer counts as a mismatch
    if (ack_o !== 1'b1) begin
      errors++;
      $display("[FAIL] ack expected 1 seen %b", ack_o);
    end
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Waits for k start pulses, then until no channel is busy
  task automatic wait_idle(input int k);
    int n;
    n = 0;
    while (starts < k && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    do begin
      wb(1'b0, 16'he001, 16'h0000);
      n++;
    end while (q[7:0] !== 8'h00 && n < 600);
    chk("start count", k, starts);
    chk("busy clear", 16'h0000, {8'h00, q[7:0]});
  endtask
  task automatic t_cmd;
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, 16'he000, {s[0], ~s[0], s[1:0], 12'hfdf});
      wb(1'b0, 16'he000, 16'h0000);
      chk("command", {s[0], ~s[0], s[1:0], 12'hf9c}, q);
      chk("ch7 source", s[1:0], ch7_source_o);
      chk("zero ref", !s[0], ext_zero_ref_o);
      chk("full ref", s[0], ext_full_ref_o);
    end
    chk("refused start", 0, starts);
  endtask
  task automatic t_status;
    wb(1'b1, 16'he001, 16'hffff);
    wb(1'b0, 16'he001, 16'h0000);
    chk("status", 16'h9f00, q);
    chk("buffers", 5'h1f, input_buffer_o);
  endtask
  task automatic t_single;
    adc_data_i <= 10'h2a5;
    adc_borrow_i <= 1'b1;
    wb(1'b1, 16'he00b, 16'h0000);
    wb(1'b1, 16'he000, 16'h00b8);
    wb(1'b1, 16'he000, 16'h00b9);
    wait_idle(1);
    chk("channel", 3'd6, last_chan);
    chk("masked irq", 0, irq_o);
    wb(1'b0, 16'he002, 16'h0000);
    chk("ch6 result", 16'hfa94, q);
    wb(1'b0, 16'he001, 16'h0000);
    chk("borrow", 2'b10, q[14:13]);
    wb(1'b1, 16'he00b, 16'h0001);
    chk("irq", 1, irq_o);
    wb(1'b0, 16'he00a, 16'h0000);
    chk("irq status", 16'h0001, q);
    chk("irq cleared", 0, irq_o);
  endtask
  task automatic t_pipe(input logic burst);
    int s0;
    // Each run converts its own sample so stale results cannot pass
    adc_data_i <= burst ? 10'h381 : 10'h07f;
    adc_borrow_i <= burst;
    adc_carry_i <= !burst;
    wb(1'b1, 16'he00b, 16'h0002);
    wb(1'b1, 16'he000, 16'h0720);
    s0 = starts;
    if (burst) begin
      burst_start_i <= 1'b1;
      @(posedge clk_i);
      burst_start_i <= 1'b0;
    end
    else wb(1'b1, 16'he000, 16'h0722);
    wait_idle(s0 + 8);
    wb(1'b0, 16'he004, 16'h0000);
    chk("ch0 result", burst ? 16'hfe04 : 16'h01fc, q);
    wb(1'b0, 16'he003, 16'h0000);
    chk("ch7 result", burst ? 16'hfe04 : 16'h01fc, q);
    wb(1'b0, 16'he001, 16'h0000);
    chk("carry", {burst, !burst}, q[14:13]);
    chk("seq irq", 1, irq_o);
    wb(1'b0, 16'he00a, 16'h0000);
    chk("seq irq status", 16'h0002, q);
  endtask
  // Unmapped word: write ignored, read returns zero
  task automatic t_unmapped;
    wb(1'b1, 16'he00c, 16'hffff);
    wb(1'b0, 16'he00c, 16'h0000);
    chk("unmapped", 16'h0000, q);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_cmd;
    t_status;
    t_single;
    t_pipe(1'b0);
    t_pipe(1'b1);
    t_unmapped;
    give_verdict;
  end
endmodule
